// File: dv/pattern_gen_and_io_pin_ctrl_props.sv
// port-level checks of the pattern generator and pin control block
`timescale 1ns/10ps
module pattern_gen_and_io_pin_ctrl_props (
    input wire sys_clk,
    input wire rst,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire aux_pin_in,
    input wire aux_pin_out,
    input wire aux_pin_oe,
    input wire mf_pin_in,
    input wire mf_pin_out,
    input wire mf_pin_oe,
    input wire hardware_enable_input,
    input wire primary_sink_enable,
    input wire secondary_sink_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////
    sda_out_zero_a: assert property (!sda_out) else $error("sda pin driven high");
    sda_hold_high_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("sda moved while scl high");
    sda_edge_low_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda changed outside scl low");
    aux_update_a: assert property ($changed({aux_pin_oe, aux_pin_out}) |-> !scl_in)
        else $error("aux pin changed outside a write");
    sink_update_a: assert property (
        $changed({primary_sink_enable, secondary_sink_enable}) |-> !scl_in)
        else $error("sink enable changed outside a write");
    enable_release_a: assert property (hardware_enable_input |-> !mf_pin_oe)
        else $error("pin driven while used as enable input");
    enable_source_a: assert property ($rose(hardware_enable_input) |-> $past(mf_pin_in))
        else $error("enable input rose with pin low");
    drive_gated_a: assert property (mf_pin_out |-> mf_pin_oe)
        else $error("pin level shown while released");
    reset_idle_a: assert property ($fell(rst) |-> !sda_oe && !aux_pin_oe && !mf_pin_oe
        && !primary_sink_enable && !secondary_sink_enable) else $error("outputs busy at reset");
endmodule // pattern_gen_and_io_pin_ctrl_props

bind pattern_gen_and_io_pin_ctrl pattern_gen_and_io_pin_ctrl_props u_props (
    .sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .aux_pin_in(aux_pin_in), .aux_pin_out(aux_pin_out),
    .aux_pin_oe(aux_pin_oe), .mf_pin_in(mf_pin_in), .mf_pin_out(mf_pin_out),
    .mf_pin_oe(mf_pin_oe), .hardware_enable_input(hardware_enable_input),
    .primary_sink_enable(primary_sink_enable), .secondary_sink_enable(secondary_sink_enable));

// File: dv/pattern_gen_and_io_pin_ctrl_tb.sv
// self-checking bench for the pattern generator and pin control block
`timescale 1ns/10ps
`include "pattern_gen_defines.vh"
`define CMP_VAL(nm, ex, got) begin compares++; if ((got) !== (ex)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module pattern_gen_and_io_pin_ctrl_tb;
    localparam [23:0] C1  = 24'd20;
    localparam [23:0] C2  = 24'd30;
    localparam [23:0] C3  = 24'd40;
    localparam [6:0]  DEV = 7'h2A; // arbitrary value
    reg  sys_clk = 1'b0;
    reg  rst = 1'b1;
    reg  scl_m = 1'b1;
    reg  sda_m = 1'b1;
    reg  ext_mf_en = 1'b0;
    reg  ext_mf_lvl = 1'b1;
    reg  ext_aux_lvl = 1'b1;
    wire sda_out, sda_oe, aux_pin_out, aux_pin_oe, mf_pin_out, mf_pin_oe, led_on;
    wire hardware_enable_input, primary_sink_enable, secondary_sink_enable;
    wire mf_pin_in, aux_pin_in;
    wire sda_line = sda_m & ~sda_oe;
    int  num_errors = 0;
    int  compares = 0;

    pattern_gen_and_io_pin_ctrl #(.DEV_ADDR(DEV), .BIT_CYC1(C1), .BIT_CYC2(C2), .BIT_CYC3(C3))
    u_pattern_gen_and_io_pin_ctrl (
        .sys_clk(sys_clk), .rst(rst), .scl_in(scl_m), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .aux_pin_in(aux_pin_in), .aux_pin_out(aux_pin_out),
        .aux_pin_oe(aux_pin_oe), .mf_pin_in(mf_pin_in), .mf_pin_out(mf_pin_out),
        .mf_pin_oe(mf_pin_oe), .hardware_enable_input(hardware_enable_input),
        .primary_sink_enable(primary_sink_enable),
        .secondary_sink_enable(secondary_sink_enable));
    pin_partner u_pin_partner (
        .mf_pin_out(mf_pin_out), .mf_pin_oe(mf_pin_oe), .aux_pin_out(aux_pin_out),
        .aux_pin_oe(aux_pin_oe), .ext_mf_en(ext_mf_en), .ext_mf_lvl(ext_mf_lvl),
        .ext_aux_lvl(ext_aux_lvl), .mf_pin_in(mf_pin_in), .aux_pin_in(aux_pin_in),
        .led_on(led_on));
    always #5 sys_clk = ~sys_clk;
    ////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    function automatic int bit_cyc(input [1:0] p);
        case (p)
            2'b00: bit_cyc = `BIT_CYC0;
            2'b01: bit_cyc = C1;
            2'b10: bit_cyc = C2;
            default: bit_cyc = C3;
        endcase
    endfunction
    function automatic int frame_slots(input [2:0] d);
        frame_slots = 32 * ((d == 3'd5) ? 6 : d);
    endfunction
    ////////////////////////////////////////
    // slave samples pins 4 clocks late, so data moves 5 clocks after scl falls
    task automatic bus_start();
        sda_m <= 1'b1;
        cyc(8);
        scl_m <= 1'b1;
        cyc(8);
        sda_m <= 1'b0;
        cyc(8);
        scl_m <= 1'b0;
        cyc(4);
    endtask
    task automatic bus_stop();
        sda_m <= 1'b0;
        cyc(8);
        scl_m <= 1'b1;
        cyc(8);
        sda_m <= 1'b1;
        cyc(8);
    endtask
    task automatic xfer(input [7:0] tx, input ackb, output [7:0] rx, output ack);
        reg b;
        for (int i = 8; i >= 0; i--) begin
            sda_m <= (i == 0) ? ackb : tx[i-1];
            cyc(8);
            scl_m <= 1'b1;
            cyc(4);
            b = sda_line;
            cyc(4);
            scl_m <= 1'b0;
            cyc(4);
            if (i > 0) rx[i-1] = b; else ack = b;
        end
    endtask
    task automatic reg_wr(input [7:0] a, input [7:0] d);
        reg [7:0] rx;
        reg [2:0] ak;
        bus_start();
        xfer({DEV, 1'b0}, 1'b1, rx, ak[2]);
        xfer(a, 1'b1, rx, ak[1]);
        xfer(d, 1'b1, rx, ak[0]);
        bus_stop();
        `CMP_VAL("write ack", 3'b000, ak)
    endtask
    task automatic rd_chk(input [7:0] a, input [7:0] ex);
        reg [7:0] rx;
        reg [2:0] ak;
        reg       nk;
        bus_start();
        xfer({DEV, 1'b0}, 1'b1, rx, ak[2]);
        xfer(a, 1'b1, rx, ak[1]);
        bus_start();
        xfer({DEV, 1'b1}, 1'b1, rx, ak[0]);
        xfer(8'hFF, 1'b1, rx, nk);
        bus_stop();
        `CMP_VAL("read ack", 3'b000, ak)
        `CMP_VAL("reg read", ex, rx)
    endtask
    task automatic watch_frame(input [31:0] pat, input int bc, input int slots);
        int n;
        int s;
        n = 0;
        while (mf_pin_oe !== 1'b1 && n < 2000) begin
            cyc(1);
            n++;
        end
        if (n >= 2000) begin
            `CMP_VAL("pattern start", 1'b1, mf_pin_oe)
            finish_test();
        end
        cyc(bc / 2);
        for (int k = 0; k < 2 * slots; k++) begin
            s = k % slots;
            `CMP_VAL("pattern pin", (s < 32) ? {pat[s], 1'b0} : 2'b00, {mf_pin_oe, mf_pin_out})
            `CMP_VAL("led", (s < 32) ? pat[s] : 1'b0, led_on)
            cyc(bc);
        end
    endtask
    ////////////////////////////////////////
    initial begin
        reg [7:0]  v;
        reg [31:0] pat;
        reg [2:0]  d;
        reg [1:0]  p;
        reg        lvl;
        void'($urandom(32'hDF1C));
        cyc(4);
        rst <= 1'b0;
        cyc(4);
        rd_chk(`REG_AUX_PIN, 8'hFE);
        for (int a = 0; a < 4; a++) rd_chk(8'(`REG_PAT0 + a), 8'h00);
        repeat (3) begin
            v = 8'($urandom) | 8'h01;
            reg_wr(`REG_AUX_PIN, v);
            `CMP_VAL("aux drive", {1'b1, v[1]}, {aux_pin_oe, aux_pin_out})
            rd_chk(`REG_AUX_PIN, {6'h3F, v[1], 1'b1});
            lvl = 1'($urandom);
            ext_aux_lvl <= lvl;
            reg_wr(`REG_AUX_PIN, v & 8'hFE);
            `CMP_VAL("aux oe", 1'b0, aux_pin_oe)
            rd_chk(`REG_AUX_PIN, {6'h3F, lvl, 1'b0});
        end
        reg_wr(8'h20, 8'h5A);
        rd_chk(8'h20, 8'h00);
        bus_start();
        xfer({~DEV, 1'b0}, 1'b1, v, lvl);
        bus_stop();
        `CMP_VAL("foreign ack", 1'b1, lvl)
        for (int k = 0; k < 5; k++) begin
            p = (k % 4 == 0) ? 2'b11 : 2'(k - 1);
            reg_wr(`REG_SINK_EN, {5'h00, p, 1'b0});
            `CMP_VAL("sinks", p, {secondary_sink_enable, primary_sink_enable})
        end
        reg_wr(`REG_PIN_FUNC, 8'h00);
        ext_mf_en <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            ext_mf_lvl <= k[0];
            cyc(10);
            `CMP_VAL("enable in", {k[0], 1'b0}, {hardware_enable_input, mf_pin_oe})
        end
        // general-purpose mode of the multifunction pin: drive high, then read back
        reg_wr(`REG_PIN_FUNC, 8'h05);
        `CMP_VAL("gpio drive", 2'b11, {mf_pin_oe, mf_pin_out})
        lvl = 1'($urandom);
        ext_mf_lvl <= lvl;
        reg_wr(`REG_PIN_FUNC, 8'h03);
        rd_chk(`REG_PIN_FUNC, {5'h00, lvl, 2'b11});
        ext_mf_en <= 1'b0;
        // pattern bit 0 forced on so the first drive marks slot 0
        for (int i = 0; i < 5; i++) begin
            d = 3'(i + 1);
            p = (i == 4) ? 2'b01 : 2'(i);
            pat = $urandom | 32'h1;
            for (int a = 0; a < 4; a++) reg_wr(8'(`REG_PAT0 + a), pat[8*a +: 8]);
            reg_wr(`REG_PIN_FUNC, {p, d, 3'b000});
            fork
                reg_wr(`REG_PIN_FUNC, {p, 3'b111, 3'b001});
                watch_frame(pat, bit_cyc(p), frame_slots(d));
            join
        end
        reg_wr(`REG_PIN_FUNC, 8'h00);
        // second reset in mid-run must bring the power-on values back
        ext_aux_lvl <= 1'b1;
        rst <= 1'b1;
        cyc(4);
        rst <= 1'b0;
        cyc(4);
        `CMP_VAL("reset pins", 3'b000, {aux_pin_oe, secondary_sink_enable, primary_sink_enable})
        rd_chk(`REG_AUX_PIN, 8'hFE);
        rd_chk(`REG_PAT3, 8'h00);
        finish_test();
    end
endmodule // pattern_gen_and_io_pin_ctrl_tb

// File: dv/pin_partner.sv
// indicator load on the pattern pin and external source on the aux pin
`timescale 1ns/10ps
module pin_partner (
    input  wire mf_pin_out,
    input  wire mf_pin_oe,
    input  wire aux_pin_out,
    input  wire aux_pin_oe,
    input  wire ext_mf_en,
    input  wire ext_mf_lvl,
    input  wire ext_aux_lvl,
    output wire mf_pin_in,
    output wire aux_pin_in,
    output wire led_on
);
    // pull-up on the pattern pin, so a released pin reads high unless ext_mf_en drives it, never a stale level
    assign mf_pin_in  = mf_pin_oe ? mf_pin_out : (ext_mf_en ? ext_mf_lvl : 1'b1);
    assign led_on     = mf_pin_oe & ~mf_pin_out;
    assign aux_pin_in = aux_pin_oe ? aux_pin_out : ext_aux_lvl;
endmodule // pin_partner

// File: hw/pattern_gen_and_io_pin_ctrl.v
// i2c register slave, aux pin, multifunction pin pattern generator and sink enables
`timescale 1ns/10ps
`include "pattern_gen_defines.vh"

module pattern_gen_and_io_pin_ctrl #(
    parameter [6:0]  DEV_ADDR  = `I2C_ADDR_DEFAULT, // arbitrary value
    parameter [23:0] BIT_CYC1  = `BIT_CYC1,
    parameter [23:0] BIT_CYC2  = `BIT_CYC2,
    parameter [23:0] BIT_CYC3  = `BIT_CYC3
) (
    input  wire sys_clk,
    input  wire rst,
    input  wire scl_in,
    input  wire sda_in,
    output reg  sda_out,
    output reg  sda_oe,
    input  wire aux_pin_in,
    output reg  aux_pin_out,
    output reg  aux_pin_oe,
    input  wire mf_pin_in,
    output reg  mf_pin_out,
    output reg  mf_pin_oe,
    output reg  hardware_enable_input,
    output reg  primary_sink_enable,
    output reg  secondary_sink_enable
);

localparam [4:0] ST_IDLE = 5'b00001;
localparam [4:0] ST_RX   = 5'b00010;
localparam [4:0] ST_ACK  = 5'b00100;
localparam [4:0] ST_TX   = 5'b01000;
localparam [4:0] ST_MACK = 5'b10000;

localparam [23:0] BIT_CYC0 = `BIT_CYC0;

////////////////////////////////////////////////////////////////////////////////
// pin input conditioning: three flops, change accepted when 2nd and 3rd agree
reg  [3:0] sync1_r;
reg  [3:0] sync2_r;
reg  [3:0] sync3_r;
reg  [3:0] filt_r;
reg  [3:0] filt_d_r;
wire [3:0] agree = ~(sync2_r ^ sync3_r);

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        sync1_r  <= 4'hF;
        sync2_r  <= 4'hF;
        sync3_r  <= 4'hF;
        filt_r   <= 4'hF;
        filt_d_r <= 4'hF;
    end else begin
        sync1_r  <= {mf_pin_in, aux_pin_in, sda_in, scl_in};
        sync2_r  <= sync1_r;
        sync3_r  <= sync2_r;
        filt_r   <= (sync2_r & agree) | (filt_r & ~agree);
        filt_d_r <= filt_r;
    end
end

wire scl      = filt_r[0];
wire sda      = filt_r[1];
wire aux_lvl  = filt_r[2];
wire mf_lvl   = filt_r[3];
wire scl_rise = filt_r[0] & ~filt_d_r[0];
wire scl_fall = ~filt_r[0] & filt_d_r[0];
wire i2c_start = scl & filt_d_r[0] & ~sda & filt_d_r[1];
wire i2c_stop  = scl & filt_d_r[0] & sda & ~filt_d_r[1];

////////////////////////////////////////////////////////////////////////////////
// registers
reg  [7:0]  pin_func_r;
reg  [1:0]  aux_pin_ctrl_r;
reg  [31:0] pattern_r;
reg  [2:0]  sink_en_r;
reg  [31:0] shift_r;
reg         restart_r;
reg  [7:0]  ptr_r;

wire [2:0] duty      = pin_func_r[5:3];
wire       pat_mode  = pin_func_r[`FUNC_CTRL_BIT] & (duty != `DUTY_GPIO);
wire       gpio_mode = pin_func_r[`FUNC_CTRL_BIT] & (duty == `DUTY_GPIO);

reg  [7:0] rd_data;
always @* begin
    case (ptr_r)
        `REG_PIN_FUNC: begin
            rd_data = pin_func_r;
            if (gpio_mode && pin_func_r[`FUNC_DIR_BIT])
                rd_data[`FUNC_DATA_BIT] = mf_lvl;
        end
        `REG_AUX_PIN: begin
            rd_data = {`AUX_PIN_FIXED,
                       aux_pin_ctrl_r[0] ? aux_pin_ctrl_r[1] : aux_lvl,
                       aux_pin_ctrl_r[0]};
        end
        `REG_PAT0:    rd_data = pattern_r[7:0];
        `REG_PAT1:    rd_data = pattern_r[15:8];
        `REG_PAT2:    rd_data = pattern_r[23:16];
        `REG_PAT3:    rd_data = pattern_r[31:24];
        `REG_SINK_EN: rd_data = {5'h00, sink_en_r};
        default:      rd_data = 8'h00;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
// i2c slave: address byte, pointer byte, then data bytes with auto increment
reg [4:0] state_r;
reg [7:0] sh_r;
reg [3:0] cnt_r;
reg [1:0] byte_idx_r;
reg       rw_r;
reg       mack_r;
reg       wr_r;
reg [7:0] wr_data_r;
reg [7:0] wr_addr_r;

always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        state_r    <= ST_IDLE;
        sh_r       <= 8'h00;
        cnt_r      <= 4'h0;
        byte_idx_r <= 2'd0;
        rw_r       <= 1'b0;
        mack_r     <= 1'b0;
        ptr_r      <= 8'h00;
        sda_oe     <= 1'b0;
        sda_out    <= 1'b0;
        wr_r       <= 1'b0;
        wr_data_r  <= 8'h00;
        wr_addr_r  <= 8'h00;
    end else begin
        wr_r    <= 1'b0;
        sda_out <= 1'b0;
        if (i2c_start) begin
            state_r    <= ST_RX;
            cnt_r      <= 4'h0;
            byte_idx_r <= 2'd0;
            sda_oe     <= 1'b0;
        end else if (i2c_stop) begin
            state_r <= ST_IDLE;
            sda_oe  <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: sda_oe <= 1'b0;
                ST_RX: begin
                    if (scl_rise) begin
                        sh_r  <= {sh_r[6:0], sda};
                        cnt_r <= cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == 4'h8) begin
                        if (byte_idx_r == 2'd0) begin
                            if (sh_r[7:1] == DEV_ADDR) begin
                                rw_r    <= sh_r[0];
                                sda_oe  <= 1'b1;
                                state_r <= ST_ACK;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end else begin
                            if (byte_idx_r == 2'd1) begin
                                ptr_r <= sh_r;
                            end else begin
                                wr_r      <= 1'b1;
                                wr_addr_r <= ptr_r;
                                wr_data_r <= sh_r;
                                ptr_r     <= ptr_r + 8'h01;
                            end
                            sda_oe  <= 1'b1;
                            state_r <= ST_ACK;
                        end
                        if (byte_idx_r != 2'd2)
                            byte_idx_r <= byte_idx_r + 2'd1;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        cnt_r <= 4'h0;
                        if (rw_r) begin
                            sh_r    <= rd_data;
                            sda_oe  <= ~rd_data[7];
                            ptr_r   <= ptr_r + 8'h01;
                            state_r <= ST_TX;
                        end else begin
                            sda_oe  <= 1'b0;
                            state_r <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_r == 4'h7) begin
                            sda_oe  <= 1'b0;
                            state_r <= ST_MACK;
                        end else begin
                            cnt_r  <= cnt_r + 4'h1;
                            sh_r   <= {sh_r[6:0], 1'b0};
                            sda_oe <= ~sh_r[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        mack_r <= ~sda;
                    end else if (scl_fall) begin
                        if (mack_r) begin
                            cnt_r   <= 4'h0;
                            sh_r    <= rd_data;
                            sda_oe  <= ~rd_data[7];
                            ptr_r   <= ptr_r + 8'h01;
                            state_r <= ST_TX;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    sda_oe  <= 1'b0;
                end
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// register writes
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        pin_func_r     <= `PIN_FUNC_RESET;
        aux_pin_ctrl_r <= `AUX_CTRL_RESET;
        pattern_r      <= 32'h0000_0000;
        sink_en_r      <= `SINK_EN_RESET;
        shift_r        <= 32'h0000_0000;
        restart_r      <= 1'b0;
    end else begin
        restart_r <= 1'b0;
        if (wr_r) begin
            case (wr_addr_r)
                `REG_PIN_FUNC: begin
                    // latch code is a command, so the stored duty keeps its value
                    if (wr_data_r[5:3] == `DUTY_LATCH) begin
                        shift_r <= pattern_r;
                        pin_func_r <= {wr_data_r[7:6], pin_func_r[5:3], wr_data_r[2:0]};
                    end else begin
                        pin_func_r <= wr_data_r;
                    end
                    restart_r <= 1'b1;
                end
                `REG_AUX_PIN: aux_pin_ctrl_r <= wr_data_r[1:0];
                `REG_PAT0:    pattern_r[7:0]   <= wr_data_r;
                `REG_PAT1:    pattern_r[15:8]  <= wr_data_r;
                `REG_PAT2:    pattern_r[23:16] <= wr_data_r;
                `REG_PAT3:    pattern_r[31:24] <= wr_data_r;
                `REG_SINK_EN: sink_en_r <= wr_data_r[2:0];
                default: ;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// pattern timing
reg [23:0] bit_len;
reg [7:0]  frame_len;
always @* begin
    case (pin_func_r[7:6])
        2'b00:   bit_len = BIT_CYC0;
        2'b01:   bit_len = BIT_CYC1;
        2'b10:   bit_len = BIT_CYC2;
        default: bit_len = BIT_CYC3;
    endcase
    case (duty)
        `DUTY_HALF:    frame_len = `FRAME_HALF;
        `DUTY_THIRD:   frame_len = `FRAME_THIRD;
        `DUTY_QUARTER: frame_len = `FRAME_QUARTER;
        `DUTY_FULL:    frame_len = `FRAME_FULL;
        default:       frame_len = `FRAME_SIXTH;
    endcase
end

reg [23:0] tick_r;
reg [7:0]  slot_r;
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        tick_r <= 24'h00_0000;
        slot_r <= 8'h00;
    end else if (!pat_mode || restart_r) begin
        tick_r <= 24'h00_0000;
        slot_r <= 8'h00;
    end else if (tick_r >= bit_len - 24'h00_0001) begin
        tick_r <= 24'h00_0000;
        // frame wrap returns to bit 0 of the latest latched pattern
        if (slot_r >= frame_len - 8'h01)
            slot_r <= 8'h00;
        else
            slot_r <= slot_r + 8'h01;
    end else begin
        tick_r <= tick_r + 24'h00_0001;
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin outputs
always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
        aux_pin_out           <= 1'b0;
        aux_pin_oe            <= 1'b0;
        mf_pin_out            <= 1'b0;
        mf_pin_oe             <= 1'b0;
        hardware_enable_input <= 1'b0;
        primary_sink_enable   <= 1'b0;
        secondary_sink_enable <= 1'b0;
    end else begin
        aux_pin_oe  <= aux_pin_ctrl_r[0];
        aux_pin_out <= aux_pin_ctrl_r[0] & aux_pin_ctrl_r[1];
        hardware_enable_input <= ~pin_func_r[`FUNC_CTRL_BIT] & mf_lvl;
        primary_sink_enable   <= sink_en_r[1];
        secondary_sink_enable <= sink_en_r[2];
        if (pat_mode) begin
            mf_pin_out <= 1'b0;
            // slots past bit 31 are the dead time; open drain there
            mf_pin_oe  <= (slot_r < `PATTERN_BITS) & shift_r[slot_r[4:0]];
        end else if (gpio_mode && !pin_func_r[`FUNC_DIR_BIT]) begin
            mf_pin_out <= pin_func_r[`FUNC_DATA_BIT];
            mf_pin_oe  <= 1'b1;
        end else begin
            mf_pin_out <= 1'b0;
            mf_pin_oe  <= 1'b0;
        end
    end
end

endmodule // pattern_gen_and_io_pin_ctrl

// File: pkg/pattern_gen_defines.vh
// register map, field positions and timing counts of the pattern and pin control block
// Operation
// - aux pin direction 0 makes it an input; bit 1 reads its level; reset default.
// - aux pin direction 1 drives the pin at the level held in bit 1.
// - aux pin control sits at 0x81, resets to 0xFC, bits 7..2 read one.
// - pattern bytes 0x90..0x93 hold 32 bits, sent bit 0 of 0x90 first.
// - pattern bit one pulls the multifunction pin low, zero leaves it open.
// - repetition is 32 bit periods over duty; pin floats for the remainder.
// - writing 111 to function bits 5..3 latches pattern bytes into the shifter.
// - primary sink enable bit 1 at zero switches the primary sink off.
// - secondary sink enable bit 2 at zero switches the secondary sink off.
// - a one in either sink enable bit switches that sink back on.
// - function bit 0 at zero makes the pin a hardware enable input.
// - bit period codes 00..11 give 1.6 us, 26 ms, 52 ms, 105 ms.
// - duty codes 010..101 give 1/2, 1/3, 1/4, 1/6; full duty repeats.
`ifndef PATTERN_GEN_DEFINES_VH
`define PATTERN_GEN_DEFINES_VH

`define REG_PIN_FUNC        8'h80
`define REG_AUX_PIN         8'h81
`define REG_PAT0            8'h90
`define REG_PAT1            8'h91
`define REG_PAT2            8'h92
`define REG_PAT3            8'h93
`define REG_SINK_EN         8'h10

`define PIN_FUNC_RESET      8'h01
`define AUX_PIN_RESET       8'hFC
`define AUX_PIN_FIXED       6'h3F
`define AUX_CTRL_RESET      2'h0
`define SINK_EN_RESET       3'h0

`define FUNC_CTRL_BIT       0
`define FUNC_DIR_BIT        1
`define FUNC_DATA_BIT       2
`define DUTY_LATCH          3'b111
`define DUTY_GPIO           3'b000
`define DUTY_FULL           3'b001
`define DUTY_HALF           3'b010
`define DUTY_THIRD          3'b011
`define DUTY_QUARTER        3'b100
`define DUTY_SIXTH          3'b101

`define PATTERN_BITS        8'd32
`define FRAME_FULL          8'd32
`define FRAME_HALF          8'd64
`define FRAME_THIRD         8'd96
`define FRAME_QUARTER       8'd128
`define FRAME_SIXTH         8'd192

`define CLK_PERIOD_NS       10
`define BIT_TIME0_NS        1600
`define BIT_TIME1_NS        26000000
`define BIT_TIME2_NS        52000000
`define BIT_TIME3_NS        105000000
`define BIT_CYC0            24'h0000A0
`define BIT_CYC1            24'h27AC40
`define BIT_CYC2            24'h4F5880
`define BIT_CYC3            24'hA037A0

`define I2C_ADDR_DEFAULT    7'h36

`endif
